// file: pkg/rtcad_pkg.sv
/*
 * Shared constants and types for the clock alarm and drift trim block:
 * register offsets, field positions, reset values, mask codes and the
 * packed state record of the top module.
 * Assumes a single 200 MHz APB clock domain; the timekeeping counters
 * live outside and feed this block with ticks and time digits.
 */
package rtcad_pkg;

   // ----------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------
   localparam int           APB_AW          = 8;
   localparam logic [7:0]   OFF_CFG_TRIM    = 8'h00;
   localparam logic [7:0]   OFF_ALARM_CFG   = 8'h04;
   localparam logic [7:0]   OFF_AL_MDY      = 8'h08;
   localparam logic [7:0]   OFF_AL_WDHR     = 8'h0c;
   localparam logic [7:0]   OFF_AL_MINSEC   = 8'h10;
   localparam logic [7:0]   OFF_STATUS      = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int           POS_TIMER_RUN   = 15;
   localparam int           POS_ALARM_EN    = 15;
   localparam int           POS_INDEF_RPT   = 14;
   localparam int           POS_MASK_LO     = 10;
   localparam int           POS_STAT_PULSE  = 0;
   localparam int           POS_STAT_BUSY   = 1;
   localparam int           POS_STAT_NEG    = 2;

   // Implemented BCD bits of the compare words, others read zero
   localparam logic [15:0]  MDY_BITS        = 16'h1f3f;
   localparam logic [15:0]  WDHR_BITS       = 16'h073f;
   localparam logic [15:0]  MINSEC_BITS     = 16'h7f7f;

   // ----------------------------------------------------------------
   // Reset values and the repeat-count wrap value
   // ----------------------------------------------------------------
   localparam logic [7:0]   RST_TRIM        = 8'h00;
   localparam logic [3:0]   RST_MASK        = 4'h0;
   localparam logic [7:0]   RST_RPT         = 8'h00;
   localparam logic [15:0]  RST_WORD        = 16'h0000;
   localparam logic [7:0]   RPT_WRAP        = 8'hff;

   // ----------------------------------------------------------------
   // Trim and mask codes
   // ----------------------------------------------------------------
   localparam int           PULSES_PER_STEP = 4;
   localparam int           TRIM_SHIFT      = $clog2(PULSES_PER_STEP);
   localparam int           TRIM_LEFT_W     = 8 + TRIM_SHIFT;

   localparam logic [3:0]   MSK_HALF_SEC    = 4'h0;
   localparam logic [3:0]   MSK_SEC         = 4'h1;
   localparam logic [3:0]   MSK_TEN_SEC     = 4'h2;
   localparam logic [3:0]   MSK_MIN         = 4'h3;
   localparam logic [3:0]   MSK_TEN_MIN     = 4'h4;
   localparam logic [3:0]   MSK_HOUR        = 4'h5;
   localparam logic [3:0]   MSK_DAY         = 4'h6;
   localparam logic [3:0]   MSK_WEEK        = 4'h7;
   localparam logic [3:0]   MSK_MONTH       = 4'h8;
   localparam logic [3:0]   MSK_YEAR        = 4'h9;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic {TRIM_IDLE, TRIM_RUN} rtcad_trim_e;

   typedef struct packed {
      logic                   timer_run;
      logic [7:0]             trim;
      logic                   alarm_enable;
      logic                   indefinite_repeat;
      logic [3:0]             alarm_interval_mask;
      logic [7:0]             alarm_repeat_count;
      logic [15:0]            al_mdy;
      logic [15:0]            al_wdhr;
      logic [15:0]            al_minsec;
      rtcad_trim_e            tstate;
      logic                   trim_neg;
      logic [TRIM_LEFT_W-1:0] trim_left;
      logic                   trim_add;
      logic                   trim_drop;
      logic                   irq;
      logic                   alarm_pulse;
      logic                   pready;
      logic                   pslverr;
      logic [31:0]            prdata;
   } rtcad_state_s;

endpackage

// file: rtl/rtcad_match.sv
/*
 * Alarm digit comparator: decides whether the current time matches the
 * alarm compare words under the selected interval mask.
 * Assumes time and alarm words share the same BCD layout and that the
 * caller qualifies the result with the half-second tick.
 */
`timescale 1ns/1ps
module rtcad_match
   import rtcad_pkg::*;
(
   // Selection
   input  wire logic [3:0]  mask,
   input  wire logic        second_edge,
   // Current time digits
   input  wire logic [15:0] tm_mdy,
   input  wire logic [15:0] tm_wdhr,
   input  wire logic [15:0] tm_minsec,
   // Alarm compare digits
   input  wire logic [15:0] al_mdy,
   input  wire logic [15:0] al_wdhr,
   input  wire logic [15:0] al_minsec,
   // Result
   output logic             match
);
   import rtcad_pkg::*;

   logic sec1_eq, sec_eq, min1_eq, min_eq, hour_eq, weekday_digit_eq, day_eq, mon_eq;

   // Per-digit equality
   always_comb begin
      sec1_eq = tm_minsec[3:0] == al_minsec[3:0];
      sec_eq  = tm_minsec[6:0] == al_minsec[6:0];
      min1_eq = tm_minsec[11:8] == al_minsec[11:8];
      min_eq  = tm_minsec[14:8] == al_minsec[14:8];
      hour_eq = tm_wdhr[5:0] == al_wdhr[5:0];
      weekday_digit_eq = tm_wdhr[10:8] == al_wdhr[10:8];
      day_eq  = tm_mdy[5:0] == al_mdy[5:0];
      mon_eq  = tm_mdy[12:8] == al_mdy[12:8];
   end

   // Wider intervals add digits on top of the narrower ones; month swaps the weekday digit for the day digits
   always_comb begin
      case (mask)
         MSK_HALF_SEC: match = 1'b1;
         MSK_SEC:      match = second_edge;
         MSK_TEN_SEC:  match = second_edge & sec1_eq;
         MSK_MIN:      match = second_edge & sec_eq;
         MSK_TEN_MIN:  match = second_edge & sec_eq & min1_eq;
         MSK_HOUR:     match = second_edge & sec_eq & min_eq;
         MSK_DAY:      match = second_edge & sec_eq & min_eq & hour_eq;
         MSK_WEEK:     match = second_edge & sec_eq & min_eq & hour_eq & weekday_digit_eq;
         MSK_MONTH:    match = second_edge & sec_eq & min_eq & hour_eq & day_eq;
         // Full date compare, so a leap-day setting only hits in leap years
         MSK_YEAR:     match = second_edge & sec_eq & min_eq & hour_eq & day_eq & mon_eq;
         default:      match = 1'b0;
      endcase
   end

endmodule

// file: rtl/rtcad_top.sv
/*
 * Alarm sequencer and per-minute drift trim of a real-time clock, with an
 * APB register slave. One state record, one combinational next-state
 * process and one register process.
 * Assumes the timekeeping counters sit outside: they supply the crystal
 * pulse tick, the minute tick, the half-second tick and the BCD time words,
 * all synchronous to pclk, and they consume the trim add/drop pulses.
 */
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps

module rtcad_top
   import rtcad_pkg::*;
(
   // Clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [rtcad_pkg::APB_AW-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic                             pready,
   output logic                             pslverr,
   output logic [31:0]                      prdata,
   // Timebase from the timekeeping counters
   input  wire logic                        osc_tick,
   input  wire logic                        minute_tick,
   input  wire logic                        half_tick,
   input  wire logic                        second_edge,
   input  wire logic [15:0]                 tm_mdy,
   input  wire logic [15:0]                 tm_wdhr,
   input  wire logic [15:0]                 tm_minsec,
   // Trim requests to the timer counter
   output logic                             trim_add,
   output logic                             trim_drop,
   // Alarm outputs
   output logic                             alarm_irq,
   output logic                             alarm_pulse
);
   import rtcad_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   rtcad_state_s q, d;
   logic         match;
   logic         alarm_evt;
   logic         setup;
   logic         wr_acc;
   logic [7:0]   trim_mag;

   // Byte-lane merge used by every writable register
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] wdat,
                                           input logic [3:0]  strb);
      logic [15:0] r;
      r = old_v;
      if (strb[0]) begin
         r[7:0] = wdat[7:0];
      end
      if (strb[1]) begin
         r[15:8] = wdat[15:8];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Digit comparator
   // ----------------------------------------------------------------
   rtcad_match u_match (
      .mask        (q.alarm_interval_mask),
      .second_edge (second_edge),
      .tm_mdy      (tm_mdy),
      .tm_wdhr     (tm_wdhr),
      .tm_minsec   (tm_minsec),
      .al_mdy      (q.al_mdy),
      .al_wdhr     (q.al_wdhr),
      .al_minsec   (q.al_minsec),
      .match       (match)
   );

   // Alarm is only judged on half-second ticks
   assign alarm_evt = half_tick & q.alarm_enable & match;
   assign setup     = psel & ~penable;
   assign wr_acc    = psel & penable & q.pready & pwrite;
   assign trim_mag  = q.trim[7] ? 8'(-q.trim) : q.trim;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [15:0] cfg_w;
      cfg_w       = 16'h0000;
      d           = q;
      d.pready    = 1'b0;
      d.pslverr   = 1'b0;
      d.irq       = 1'b0;
      d.trim_add  = 1'b0;
      d.trim_drop = 1'b0;

      // Trim sequencer: load a pulse budget each minute, spend one per crystal pulse
      case (q.tstate)
         TRIM_IDLE: begin
            if (minute_tick && q.timer_run && q.trim != RST_TRIM) begin
               d.trim_neg  = q.trim[7];
               d.trim_left = {trim_mag, TRIM_SHIFT'(0)};
               d.tstate    = TRIM_RUN;
            end
         end
         TRIM_RUN: begin
            if (osc_tick) begin
               d.trim_add  = ~q.trim_neg;
               d.trim_drop = q.trim_neg;
               d.trim_left = q.trim_left - TRIM_LEFT_W'(1);
               if (q.trim_left == TRIM_LEFT_W'(1)) begin
                  d.tstate = TRIM_IDLE;
               end
            end
            // Stopping the timer abandons the rest of this minute's budget
            if (!q.timer_run) begin
               d.tstate = TRIM_IDLE;
            end
         end
         default: d.tstate = TRIM_IDLE;
      endcase

      // Alarm sequencing: interrupt, toggle, then count down or disable
      if (alarm_evt) begin
         d.irq         = 1'b1;
         d.alarm_pulse = ~q.alarm_pulse;
         if (q.alarm_repeat_count != RST_RPT) begin
            d.alarm_repeat_count = q.alarm_repeat_count - 8'h01;
         end else if (q.indefinite_repeat) begin
            d.alarm_repeat_count = RPT_WRAP;
         end else begin
            d.alarm_enable = 1'b0;
         end
      end

      // APB setup cycle: decode and prepare the answer for the access cycle
      if (setup) begin
         d.pready = 1'b1;
         d.prdata = 32'h0000_0000;
         if (paddr == OFF_CFG_TRIM) begin
            d.prdata[POS_TIMER_RUN] = q.timer_run;
            d.prdata[7:0]           = q.trim;
         end else if (paddr == OFF_ALARM_CFG) begin
            d.prdata[POS_ALARM_EN]  = q.alarm_enable;
            d.prdata[POS_INDEF_RPT] = q.indefinite_repeat;
            d.prdata[POS_MASK_LO +: 4] = q.alarm_interval_mask;
            d.prdata[7:0]           = q.alarm_repeat_count;
         end else if (paddr == OFF_AL_MDY) begin
            d.prdata[15:0] = q.al_mdy;
         end else if (paddr == OFF_AL_WDHR) begin
            d.prdata[15:0] = q.al_wdhr;
         end else if (paddr == OFF_AL_MINSEC) begin
            d.prdata[15:0] = q.al_minsec;
         end else if (paddr == OFF_STATUS) begin
            d.prdata[POS_STAT_PULSE] = q.alarm_pulse;
            d.prdata[POS_STAT_BUSY]  = q.tstate == TRIM_RUN;
            d.prdata[POS_STAT_NEG]   = q.trim_neg;
         end else begin
            d.pslverr = 1'b1;
         end
      end

      // APB write at the access edge; a same-cycle alarm update to the
      // config register is overridden so software sees what it wrote
      if (wr_acc) begin
         if (paddr == OFF_CFG_TRIM) begin
            cfg_w       = merge16({q.timer_run, 7'h00, q.trim}, pwdata, pstrb);
            d.timer_run = cfg_w[POS_TIMER_RUN];
            d.trim      = cfg_w[7:0];
         end else if (paddr == OFF_ALARM_CFG) begin
            cfg_w = merge16({q.alarm_enable, q.indefinite_repeat, q.alarm_interval_mask,
                             2'b00, q.alarm_repeat_count}, pwdata, pstrb);
            d.alarm_enable        = cfg_w[POS_ALARM_EN];
            d.indefinite_repeat   = cfg_w[POS_INDEF_RPT];
            d.alarm_interval_mask = cfg_w[POS_MASK_LO +: 4];
            d.alarm_repeat_count  = cfg_w[7:0];
         end else if (paddr == OFF_AL_MDY) begin
            d.al_mdy = merge16(q.al_mdy, pwdata, pstrb) & MDY_BITS;
         end else if (paddr == OFF_AL_WDHR) begin
            d.al_wdhr = merge16(q.al_wdhr, pwdata, pstrb) & WDHR_BITS;
         end else if (paddr == OFF_AL_MINSEC) begin
            d.al_minsec = merge16(q.al_minsec, pwdata, pstrb) & MINSEC_BITS;
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q                     <= '0;
         q.trim                <= RST_TRIM;
         q.alarm_interval_mask <= RST_MASK;
         q.alarm_repeat_count  <= RST_RPT;
         q.al_mdy              <= RST_WORD;
         q.al_wdhr             <= RST_WORD;
         q.al_minsec           <= RST_WORD;
         q.tstate              <= TRIM_IDLE;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state record
   assign pready      = q.pready;
   assign pslverr     = q.pslverr;
   assign prdata      = q.prdata;
   assign trim_add    = q.trim_add;
   assign trim_drop   = q.trim_drop;
   assign alarm_irq   = q.irq;
   assign alarm_pulse = q.alarm_pulse;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_irq_each_alarm;
      alarm_evt |=> alarm_irq ##1 !alarm_irq;
   endproperty
   a_irq_each_alarm: assert property (p_irq_each_alarm) else $error("alarm without one-cycle irq");

   property p_pulse_toggles;
      alarm_evt |=> alarm_pulse != $past(alarm_pulse);
   endproperty
   a_pulse_toggles: assert property (p_pulse_toggles) else $error("alarm pulse did not toggle");

   property p_pulse_steady;
      !alarm_evt |=> $stable(alarm_pulse);
   endproperty
   a_pulse_steady: assert property (p_pulse_steady) else $error("alarm pulse moved without alarm");

   property p_last_alarm_off;
      alarm_evt && q.alarm_repeat_count == 8'h00 && !q.indefinite_repeat && !wr_acc
         |=> !q.alarm_enable;
   endproperty
   a_last_alarm_off: assert property (p_last_alarm_off) else $error("enable kept after final alarm");

   property p_count_down;
      alarm_evt && q.alarm_repeat_count != 8'h00 && !wr_acc
         |=> q.alarm_enable && q.alarm_repeat_count == $past(q.alarm_repeat_count) - 8'h01;
   endproperty
   a_count_down: assert property (p_count_down) else $error("repeat count not decremented");

   property p_wrap;
      alarm_evt && q.alarm_repeat_count == 8'h00 && q.indefinite_repeat && !wr_acc
         |=> q.alarm_enable && q.alarm_repeat_count == 8'hff;
   endproperty
   a_wrap: assert property (p_wrap) else $error("indefinite repeat did not wrap");

   property p_bad_mask;
      q.alarm_interval_mask > 4'h9 |-> !match;
   endproperty
   a_bad_mask: assert property (p_bad_mask) else $error("undefined mask matched");

   property p_half_every_tick;
      half_tick && q.alarm_enable && q.alarm_interval_mask == 4'h0 |=> alarm_irq;
   endproperty
   a_half_every_tick: assert property (p_half_every_tick) else $error("half second alarm missed");

   property p_trim_budget;
      q.tstate == TRIM_IDLE && minute_tick && q.timer_run && q.trim != 8'h00
         |=> q.trim_left == {2'b00, $past(trim_mag)} * 10'd4;
   endproperty
   a_trim_budget: assert property (p_trim_budget) else $error("trim budget not four per step");

   property p_trim_dir;
      (trim_add |-> !q.trim_neg && !trim_drop) and (trim_drop |-> q.trim_neg);
   endproperty
   a_trim_dir: assert property (p_trim_dir) else $error("trim pulse in wrong direction");

   property p_apb_answer;
      setup |=> pready ##1 !pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb answer not one cycle after setup");

   property p_tick_needed;
      !half_tick |=> !alarm_irq;
   endproperty
   a_tick_needed: assert property (p_tick_needed) else $error("alarm irq without half tick");

   property p_trim_idle_quiet;
      q.tstate == TRIM_IDLE |=> !trim_add && !trim_drop;
   endproperty
   a_trim_idle_quiet: assert property (p_trim_idle_quiet) else $error("trim pulse while idle");

   property p_trim_per_tick;
      !osc_tick |=> !trim_add && !trim_drop;
   endproperty
   a_trim_per_tick: assert property (p_trim_per_tick) else $error("trim pulse without crystal pulse");

   property p_stop_aborts;
      q.tstate == TRIM_RUN && !q.timer_run |=> q.tstate == TRIM_IDLE;
   endproperty
   a_stop_aborts: assert property (p_stop_aborts) else $error("trim kept running with timer stopped");

   property p_trim_readback;
      setup && paddr == OFF_CFG_TRIM |=> prdata[7:0] == $past(q.trim);
   endproperty
   a_trim_readback: assert property (p_trim_readback) else $error("trim read back wrong");

   property p_mask_readback;
      setup && paddr == OFF_ALARM_CFG |=> prdata[POS_MASK_LO +: 4] == $past(q.alarm_interval_mask);
   endproperty
   a_mask_readback: assert property (p_mask_readback) else $error("interval mask read back wrong");

   property p_minsec_bcd;
      (q.al_minsec & ~MINSEC_BITS) == 16'h0000;
   endproperty
   a_minsec_bcd: assert property (p_minsec_bcd) else $error("unused compare bit stored");

   property p_err_reads_zero;
      pslverr |-> prdata == 32'h0000_0000;
   endproperty
   a_err_reads_zero: assert property (p_err_reads_zero) else $error("error answer with nonzero data");

   property p_whole_second;
      q.alarm_interval_mask != MSK_HALF_SEC && !second_edge |-> !match;
   endproperty
   a_whole_second: assert property (p_whole_second) else $error("match off a whole second");

endmodule

// file: tb/rtcad_tb.sv
/*
 * Self-checking bench of the alarm sequencer and drift trim block.
 * Assumes APB answers come by pready, however late, and that the bench
 * plays the timekeeping counters: ticks and BCD time words.
 */
`timescale 1ns/1ps
module tb;
   import rtcad_pkg::*;
   // -------------------------------------------------------------
   // Signals and bench state
   // -------------------------------------------------------------
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        osc_tick = 0, minute_tick = 0, half_tick = 0, second_edge = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, rd, seed = 32'hff71;
   logic [3:0]  pstrb = 0;
   logic [15:0] tm_minsec = 0, tm_mdy = 16'h0101, tm_wdhr = 16'h0000;
   logic [31:0] prdata_w;
   logic        pready, pslverr, trim_add, trim_drop, alarm_irq, alarm_pulse, er;
   int          err_total = 0, tests_run = 0, n_irq = 0, n_exp = 0, n_add = 0, n_drop = 0;
   int          cnt, en, ind, msk, ticks, bud;
   // First trim as software forms it: (ideal - measured) * 60 / 4
   logic [7:0]  trims [5] = '{8'((32768 - 32766) * 60 / 4), 8'hff, 8'h80, 8'h7f, 8'h00};
   logic [7:0]  cregs [3] = '{OFF_AL_MDY, OFF_AL_WDHR, OFF_AL_MINSEC};
   logic [15:0] cbits [3] = '{MDY_BITS, WDHR_BITS, MINSEC_BITS};

   rtcad_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata_w),
      .osc_tick(osc_tick), .minute_tick(minute_tick), .half_tick(half_tick), .second_edge(second_edge),
      .tm_mdy(tm_mdy), .tm_wdhr(tm_wdhr), .tm_minsec(tm_minsec), .trim_add(trim_add),
      .trim_drop(trim_drop), .alarm_irq(alarm_irq), .alarm_pulse(alarm_pulse));

   // Clock and output pulse counters
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (alarm_irq === 1'b1) n_irq++;
      if (trim_add === 1'b1) n_add++;
      if (trim_drop === 1'b1) n_drop++;
   end

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer; the request stands until pready is seen high at a rising edge,
   // read data is taken at that edge; only the watchdog ends a wait that never ends
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata_w;
      er = pslverr;
      psel <= 0; penable <= 0;
   endtask

   function automatic logic [31:0] cfgw();
      return {16'h0, en[0], ind[0], msk[3:0], 2'b00, cnt[7:0]};
   endfunction

   // Expected match per interval from the digit table; r[7:0] flag differing digits,
   // r[8] is the whole-second edge
   function automatic bit want(input int m, input logic [8:0] r);
      bit s1, ss, mm, hh;
      s1 = !r[0];
      ss = s1 && !r[1];
      mm = !r[2] && !r[3];
      hh = ss && mm && !r[4];
      case (m)
         1: return r[8];
         2: return r[8] && s1;
         3: return r[8] && ss;
         4: return r[8] && ss && !r[2];
         5: return r[8] && ss && mm;
         6: return r[8] && hh;
         7: return r[8] && hh && !r[5];
         8: return r[8] && hh && !r[6];
         9: return r[8] && hh && !r[6] && !r[7];
         default: return 0;
      endcase
   endfunction

   // Program the alarm between half-second ticks and mirror it in the model
   task automatic set_alarm(input int e, input int i, input int m, input int c);
      en = e; ind = i; msk = m; cnt = c;
      apb(1, OFF_ALARM_CFG, cfgw());
   endtask

   // One half-second tick; m tells whether the unmasked digits match
   task automatic half(input logic se, input bit m);
      half_tick <= 1; second_edge <= se;
      @(posedge pclk);
      half_tick <= 0; second_edge <= 0;
      repeat (2) @(posedge pclk);
      if (en != 0 && m) begin
         n_exp++;
         if (cnt != 0) cnt--;
         else if (ind != 0) cnt = 255;
         else en = 0;
      end
      chk("alarm irq count", n_irq, n_exp);
      chk("alarm pulse", alarm_pulse, n_exp % 2);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard, far beyond the expected run of about 7500 cycles
   initial begin
      #250000;
      err_total++;
      test_done();
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      apb(0, OFF_ALARM_CFG, 0);
      chk("alarm cfg reset", rd, 0);
      apb(0, 8'h18, 0);
      chk("unmapped rdata", rd, 0);
      chk("unmapped err", er, 1);
      // Compare words keep only their BCD bits
      for (int k = 0; k < 3; k++) begin
         apb(1, cregs[k], 32'hffffffff);
         apb(0, cregs[k], 0);
         chk("compare bits", rd, {16'h0, cbits[k]});
      end
      // Trim budget per minute, boundary values of the signed byte
      foreach (trims[k]) begin
         apb(1, OFF_CFG_TRIM, {16'h0, 8'h00, trims[k]});
         apb(1, OFF_CFG_TRIM, {16'h0, 8'h80, trims[k]});
         n_add = 0; n_drop = 0; ticks = 0;
         minute_tick <= 1;
         @(posedge pclk);
         minute_tick <= 0;
         repeat (1400) begin
            rd = xs();
            osc_tick <= rd[0];
            @(posedge pclk);
            if (osc_tick) ticks++;
         end
         osc_tick <= 0;
         repeat (4) @(posedge pclk);
         bud = $signed(trims[k]) < 0 ? -4 * $signed(trims[k]) : 4 * $signed(trims[k]);
         if (ticks < bud) bud = ticks;
         chk("trim adds", n_add, trims[k][7] ? 0 : bud);
         chk("trim drops", n_drop, trims[k][7] ? bud : 0);
      end
      // Count of two gives three alarms, then enable drops
      set_alarm(1, 0, MSK_HALF_SEC, 2);
      repeat (4) half(0, 1);
      apb(0, OFF_ALARM_CFG, 0);
      chk("final alarm cfg", rd, cfgw());
      apb(0, OFF_STATUS, 0);
      chk("status pulse", rd, n_exp % 2);
      // Indefinite repeat wraps the count
      set_alarm(1, 1, MSK_HALF_SEC, 0);
      repeat (2) half(0, 1);
      apb(0, OFF_ALARM_CFG, 0);
      chk("wrapped cfg", rd, cfgw());
      // Minute interval compares the seconds digits only
      set_alarm(0, 1, MSK_HALF_SEC, 0);
      apb(1, OFF_AL_MINSEC, 32'h0030);
      set_alarm(1, 1, MSK_MIN, 5);
      repeat (16) begin
         rd = xs();
         tm_minsec <= {rd[15:8], rd[0] ? 8'h30 : {1'b0, rd[7:1]}};
         half(rd[9], rd[9] && (rd[0] || rd[7:1] == 7'h30));
      end
      // Every interval from MSK_SEC to MSK_YEAR against random digit mismatches, leap-day date
      set_alarm(0, 1, MSK_HALF_SEC, 0);
      apb(1, OFF_AL_MDY, 32'h0229);
      apb(1, OFF_AL_WDHR, 32'h0323);
      apb(1, OFF_AL_MINSEC, 32'h5937);
      for (int m = 1; m < 10; m++) begin
         set_alarm(1, 1, m, 5);
         repeat (12) begin
            rd = xs();
            tm_minsec <= 16'h5937 ^ {3'h0, rd[3], 3'h0, rd[2], 3'h0, rd[1], 3'h0, rd[0]};
            tm_wdhr <= 16'h0323 ^ {7'h0, rd[5], 7'h0, rd[4]};
            tm_mdy <= 16'h0229 ^ {7'h0, rd[7], 7'h0, rd[6]};
            half(rd[8], want(m, rd[8:0]));
         end
      end
      // Undefined interval code never fires
      set_alarm(1, 0, 10, 0);
      tm_minsec <= 16'h0030;
      repeat (3) half(1, 0);
      test_done();
   end
endmodule
